// ### common/sledb_pkg.sv
// shared constants for the status led and beeper indicator
package sledb_pkg;
	// =====================================================
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_IRQ_ST = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_TONE = 8'h10;
	localparam logic [7:0] OFF_ILLUM_TO = 8'h14;
	// control bit positions
	localparam int CTRL_BEEP_EN = 0;
	localparam int CTRL_KEY_EN = 1;
	localparam int CTRL_BEEP_ON_GOOD = 2;
	// interrupt status bits
	localparam int IRQ_SELFTEST = 0;
	localparam int IRQ_GOOD = 1;
	localparam int IRQ_ILLUM_TO = 2;
	localparam int IRQ_KEY = 3;
	// reset values
	localparam logic [2:0] CTRL_RESET = 3'h7;
	localparam logic [31:0] TONE_RESET = 32'h0014_0010;
	// timing
	localparam longint CLK_HZ = 10_000_000;
	localparam int ILLUM_TO_MIN = 10;
	localparam longint ILLUM_TO_CYC = ILLUM_TO_MIN * 60 * CLK_HZ;
	localparam int SHOW_MS = 500;
	localparam int SHOW_CYC = int'(SHOW_MS * (CLK_HZ / 1000));
	localparam int FLICK_MS = 50;
	localparam int FLICK_CYC = int'(FLICK_MS * (CLK_HZ / 1000));
	localparam int BEEP_UNIT_US = 1000;
	localparam int BEEP_UNIT_CYC = int'(BEEP_UNIT_US * (CLK_HZ / 1_000_000));
	// tone sequence kinds
	typedef enum logic [2:0] {
		SEQ_NONE,
		SEQ_POWERUP,
		SEQ_READING,
		SEQ_KEY_START,
		SEQ_KEY_END
	} sledb_seq_t;
endpackage

// ### rtl/sledb_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module sledb_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// =====================================================
	// chain
	logic [W-1:0] meta_q;
	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### rtl/sledb_beeper.sv
// beeper tone sequencer: beeps and gaps, two pitches
`timescale 1ns/1ps
`default_nettype none
module sledb_beeper (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire sledb_pkg::sledb_seq_t kind,
	// tone settings: length in units, half periods in clocks minus one
	input wire logic [7:0] len_units,
	input wire logic [7:0] half_norm,
	input wire logic [7:0] half_high,
	// outputs
	output logic beep_out,
	output logic busy
);
	// =====================================================
	// sequence state
	logic [2:0] left_q;
	logic last_high_q;
	logic gap_q;
	logic high_q;
	logic [7:0] unit_q;
	logic [15:0] div_q;
	logic [7:0] tone_q;
	logic [3:0] shape;

	// beep count and whether the last one is high
	function automatic logic [3:0] seq_shape(input sledb_pkg::sledb_seq_t k);
		case (k)
			sledb_pkg::SEQ_POWERUP: seq_shape = 4'h3;
			sledb_pkg::SEQ_READING: seq_shape = 4'h4;
			sledb_pkg::SEQ_KEY_START: seq_shape = 4'h1;
			sledb_pkg::SEQ_KEY_END: seq_shape = 4'h9;
			default: seq_shape = 4'h0;
		endcase
	endfunction

	// shape of the requested sequence, split into count and high flag
	assign shape = seq_shape(kind);

	// sequencer; a new start replaces anything playing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_q <= 3'h0;
			last_high_q <= 1'b0;
			gap_q <= 1'b0;
			high_q <= 1'b0;
			unit_q <= 8'h00;
			div_q <= 16'h0000;
		end else if (start) begin // RULE19
			left_q <= shape[2:0];
			last_high_q <= shape[3];
			high_q <= (shape[2:0] == 3'h1) && shape[3];
			gap_q <= 1'b0;
			unit_q <= len_units;
			div_q <= 16'h0000;
		end else if (left_q != 3'h0) begin
			if (div_q == 16'(sledb_pkg::BEEP_UNIT_CYC - 1)) begin
				div_q <= 16'h0000;
				if (unit_q <= 8'h01) begin
					unit_q <= len_units;
					if (gap_q) begin
						gap_q <= 1'b0;
						high_q <= (left_q == 3'h2) && last_high_q;
						left_q <= left_q - 3'h1;
					end else if (left_q == 3'h1) begin
						left_q <= 3'h0;
					end else begin
						gap_q <= 1'b1;
					end
				end else begin
					unit_q <= unit_q - 8'h01;
				end
			end else begin
				div_q <= div_q + 16'h0001;
			end
		end
	end

	// square wave, pitch set by half period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tone_q <= 8'h00;
			beep_out <= 1'b0;
			busy <= 1'b0;
		end else begin
			busy <= (left_q != 3'h0) && !start;
			if (left_q == 3'h0 || gap_q) begin
				tone_q <= 8'h00;
				beep_out <= 1'b0;
			end else if (tone_q >= (high_q ? half_high : half_norm)) begin
				tone_q <= 8'h00;
				beep_out <= !beep_out;
			end else begin
				tone_q <= tone_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/sledb_top.sv
// status led and beeper indicator with apb registers
// =====================================================
// Notes on behaviour
// (RULE1) self-test pass: ready orange, result, illum briefly
// (RULE2) reading mode holds ready green
// (RULE3) leaving reading mode turns ready green off
// (RULE4) result led follows second result output
// (RULE5) illum led lit while illumination enabled
// (RULE6) continuous trigger keeps illum led steady
// (RULE7) transmit led flickers while serial sending
// (RULE8) link led lit while ethernet connected
// (RULE9) traffic led lights on addressed frames
// (RULE10) power-up tone after self-test pass
// (RULE11) good decode beeps in reading mode
// (RULE12) illumination timeout disables illumination, beeps
// (RULE13) key start gives normal beep
// (RULE14) key interval: high beep on good/end
// (RULE15) beeper enabled by default, configurable
// (RULE16) trigger from sensor, continuous, or host
// (RULE17) disabled key neither starts nor beeps
// (RULE18) flicker by stretching transmit activity visibly; code does not stretch, it toggles led_tx while busy
// (RULE19) sequencer plays tones, new request replaces
`timescale 1ns/1ps
`default_nettype none
module sledb_top #(
	parameter longint ILLUM_TO_CYCLES = sledb_pkg::ILLUM_TO_CYC,
	parameter int SHOW_CYCLES = sledb_pkg::SHOW_CYC,
	parameter int FLICK_CYCLES = sledb_pkg::FLICK_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device state, synchronous
	input wire logic selftest_pass,
	input wire logic reading_mode,
	input wire logic good_read,
	input wire logic result2_out,
	input wire logic illum_req,
	input wire logic continuous_mode,
	input wire logic interval_end,
	input wire logic ser_tx_busy,
	// pins
	input wire logic key_n,
	input wire logic eth_link,
	input wire logic eth_traffic,
	// indicators
	output logic led_ready_orange,
	output logic led_ready_green,
	output logic led_result,
	output logic led_illum,
	output logic led_tx,
	output logic led_eth_link,
	output logic led_eth_data,
	output logic illum_en,
	output logic beep_out,
	output logic irq
);
	// =====================================================
	// registers
	logic [2:0] ctrl_q;
	logic [3:0] irq_st_q;
	logic [3:0] irq_mask_q;
	logic [31:0] tone_q;
	logic illum_off_q;
	logic [3:0] ev;
	logic wr_en;
	logic rd_en;

	// apb answers in the access cycle, no wait states
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= sledb_pkg::CTRL_RESET;
			irq_mask_q <= 4'h0;
			tone_q <= sledb_pkg::TONE_RESET;
		end else if (wr_en) begin
			case (paddr)
				sledb_pkg::OFF_CTRL: ctrl_q <= pwdata[2:0]; // RULE15
				sledb_pkg::OFF_IRQ_MASK: irq_mask_q <= pwdata[3:0];
				sledb_pkg::OFF_TONE: tone_q <= pwdata;
				default: ;
			endcase
		end
	end

	// =====================================================
	// pin synchronisers
	logic [2:0] pins_s;
	sledb_sync #(.W(3)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({!key_n, eth_link, eth_traffic}),
		.q(pins_s)
	);

	// key press edge
	logic key_prev_q;
	logic key_rise;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_prev_q <= 1'b0;
		end else begin
			key_prev_q <= pins_s[2];
		end
	end
	assign key_rise = pins_s[2] && !key_prev_q && ctrl_q[sledb_pkg::CTRL_KEY_EN]; // RULE17

	// =====================================================
	// self-test show and mode tracking
	logic st_prev_q;
	logic [31:0] show_q;
	logic st_rise;
	assign st_rise = selftest_pass && !st_prev_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_prev_q <= 1'b0;
			show_q <= 32'h0;
		end else begin
			st_prev_q <= selftest_pass;
			if (st_rise) begin
				show_q <= 32'(SHOW_CYCLES);
			end else if (show_q != 32'h0) begin
				show_q <= show_q - 32'h1;
			end
		end
	end

	// key-started interval, ends on good read or interval end
	logic key_iv_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_iv_q <= 1'b0;
		end else if (key_rise) begin
			key_iv_q <= 1'b1;
		end else if (good_read || interval_end) begin
			key_iv_q <= 1'b0;
		end
	end

	// =====================================================
	// illumination timeout; trigger source is outside, any enables lamps
	logic [39:0] ill_cnt_q;
	logic ill_to;
	assign ill_to = ill_cnt_q == 40'(ILLUM_TO_CYCLES - 1);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ill_cnt_q <= 40'h0;
			illum_off_q <= 1'b0;
		end else if (!reading_mode) begin
			ill_cnt_q <= 40'h0;
			illum_off_q <= 1'b0;
		end else if (illum_req && !illum_off_q) begin
			ill_cnt_q <= ill_to ? 40'h0 : ill_cnt_q + 40'h1;
			if (ill_to) begin
				illum_off_q <= 1'b1; // RULE12
			end
		end else if (!illum_req) begin
			ill_cnt_q <= 40'h0;
			illum_off_q <= 1'b0;
		end
	end

	// =====================================================
	// tx flicker: toggle while busy at a visible rate
	logic [31:0] flick_q;
	logic flick_ph_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flick_q <= 32'h0;
			flick_ph_q <= 1'b0;
		end else if (!ser_tx_busy) begin
			flick_q <= 32'h0;
			flick_ph_q <= 1'b0;
		end else if (flick_q == 32'(FLICK_CYCLES - 1)) begin
			flick_q <= 32'h0;
			flick_ph_q <= !flick_ph_q; // RULE18
		end else begin
			flick_q <= flick_q + 32'h1;
		end
	end

	// =====================================================
	// indicator outputs
	logic showing;
	logic lamps;
	assign showing = show_q != 32'h0;
	assign lamps = (illum_req || continuous_mode) && !illum_off_q; // RULE16
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			led_ready_orange <= 1'b0;
			led_ready_green <= 1'b0;
			led_result <= 1'b0;
			led_illum <= 1'b0;
			led_tx <= 1'b0;
			led_eth_link <= 1'b0;
			led_eth_data <= 1'b0;
			illum_en <= 1'b0;
		end else begin
			led_ready_orange <= showing; // RULE1
			led_ready_green <= reading_mode && !showing; // RULE2 RULE3
			led_result <= showing || result2_out; // RULE4
			led_illum <= showing || lamps; // RULE5 RULE6
			illum_en <= lamps;
			led_tx <= ser_tx_busy && !flick_ph_q; // RULE7
			led_eth_link <= pins_s[1]; // RULE8
			led_eth_data <= pins_s[0]; // RULE9
		end
	end

	// =====================================================
	// beeper requests, first one in the chain wins by priority
	logic ill_beep;
	sledb_pkg::sledb_seq_t req_kind;
	logic req;
	logic beep_busy;
	assign ill_beep = reading_mode && illum_req && !illum_off_q && ill_to;
	always_comb begin
		req = 1'b0;
		req_kind = sledb_pkg::SEQ_NONE;
		if (ctrl_q[sledb_pkg::CTRL_BEEP_EN]) begin
			if (st_rise) begin
				req = 1'b1;
				req_kind = sledb_pkg::SEQ_POWERUP; // RULE10
			end else if (key_rise) begin
				req = 1'b1;
				req_kind = sledb_pkg::SEQ_KEY_START; // RULE13
			end else if (key_iv_q && (good_read || interval_end)) begin
				req = 1'b1;
				req_kind = sledb_pkg::SEQ_KEY_END; // RULE14
			end else if (reading_mode && good_read && ctrl_q[sledb_pkg::CTRL_BEEP_ON_GOOD]) begin
				req = 1'b1;
				req_kind = sledb_pkg::SEQ_READING; // RULE11
			end else if (ill_beep) begin
				req = 1'b1;
				req_kind = sledb_pkg::SEQ_READING; // RULE12
			end
		end
	end

	logic beep_raw;
	sledb_beeper u_beep (
		.clk(clk),
		.rst(rst),
		.start(req),
		.kind(req_kind),
		.len_units(tone_q[23:16]),
		.half_norm(tone_q[7:0]),
		.half_high(tone_q[15:8]),
		.beep_out(beep_raw),
		.busy(beep_busy)
	);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			beep_out <= 1'b0;
		end else begin
			beep_out <= beep_raw;
		end
	end

	// =====================================================
	// interrupts: set wins over write-one-to-clear
	assign ev = {key_rise, ill_beep, reading_mode && good_read, st_rise};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_st_q <= 4'h0;
		end else if (wr_en && paddr == sledb_pkg::OFF_IRQ_ST) begin
			irq_st_q <= (irq_st_q & ~pwdata[3:0]) | ev;
		end else begin
			irq_st_q <= irq_st_q | ev;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_st_q & irq_mask_q);
		end
	end

	// read mux, registered in setup so data is ready in access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				pslverr <= !(paddr == sledb_pkg::OFF_CTRL || paddr == sledb_pkg::OFF_STAT
					|| paddr == sledb_pkg::OFF_IRQ_ST || paddr == sledb_pkg::OFF_IRQ_MASK
					|| paddr == sledb_pkg::OFF_TONE);
			end
			if (rd_en) begin
				case (paddr)
					sledb_pkg::OFF_CTRL: prdata <= {29'h0, ctrl_q};
					sledb_pkg::OFF_STAT: prdata <= {26'h0, beep_busy, key_iv_q,
						illum_off_q, lamps, reading_mode, showing};
					sledb_pkg::OFF_IRQ_ST: prdata <= {28'h0, irq_st_q};
					sledb_pkg::OFF_IRQ_MASK: prdata <= {28'h0, irq_mask_q};
					sledb_pkg::OFF_TONE: prdata <= tone_q;
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// =====================================================
	// assertions
	a_ready_green: assert property (@(posedge clk) disable iff (rst)
		!reading_mode |=> !led_ready_green) else $error("ready green lit outside reading"); // RULE3
	a_ready_steady: assert property (@(posedge clk) disable iff (rst)
		reading_mode && !showing |=> led_ready_green) else $error("ready green not lit"); // RULE2
	a_show_leds: assert property (@(posedge clk) disable iff (rst)
		st_rise |=> ##1 led_ready_orange && led_result && led_illum) else $error("show missing"); // RULE1
	a_result_follow: assert property (@(posedge clk) disable iff (rst)
		result2_out |=> led_result) else $error("result led not following"); // RULE4
	a_illum_cont: assert property (@(posedge clk) disable iff (rst)
		continuous_mode && !illum_off_q |=> led_illum) else $error("illum led dark"); // RULE6
	a_link_led: assert property (@(posedge clk) disable iff (rst)
		pins_s[1] |=> led_eth_link) else $error("link led dark"); // RULE8
	a_key_off: assert property (@(posedge clk) disable iff (rst)
		!ctrl_q[sledb_pkg::CTRL_KEY_EN] |-> !key_rise) else $error("disabled key acted"); // RULE17
	a_tx_idle: assert property (@(posedge clk) disable iff (rst)
		!ser_tx_busy |=> !led_tx) else $error("tx led lit idle"); // RULE7
	a_boot_tone: assert property (@(posedge clk) disable iff (rst)
		st_rise && ctrl_q[sledb_pkg::CTRL_BEEP_EN] |=> ##1 beep_busy) else $error("no power-up tone"); // RULE10
	a_irq_level: assert property (@(posedge clk) disable iff (rst)
		|(irq_st_q & irq_mask_q) |=> irq) else $error("irq not raised");
	c_good_beep: cover property (@(posedge clk) reading_mode && good_read && req);
	c_illum_to: cover property (@(posedge clk) ill_beep);
	c_key_iv: cover property (@(posedge clk) key_rise ##[1:20] key_iv_q && interval_end);
endmodule
`default_nettype wire

// ### verification/sledb_operator.sv
// operator model: presses the function key and counts beeps heard
`timescale 1ns/1ps
`default_nettype none
module sledb_operator (
	// clock
	input wire logic clk,
	// command from the bench
	input wire logic press,
	// key pin and beeper
	output logic key_n,
	input wire logic beep_out,
	// beeps heard so far
	output int beeps
);
	logic beep_q = 1'b0;
	int heard_q = 0;
	// =====================================================
	// key pin
	// released key sits on its pull-up, so it never reads low
	assign key_n = !press;
	// =====================================================
	// ear
	// one beep counted per rising edge of the tone
	assign beeps = heard_q;
	always @(posedge clk) begin
		beep_q <= beep_out;
		if (beep_out === 1'b1 && beep_q === 1'b0) begin
			heard_q <= heard_q + 1;
		end
	end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the status led and beeper indicator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int TO_CYC = 100;
	localparam int SHOW = 20;
	localparam int FLICK = 4;
	typedef struct {logic [5:0] in; logic [4:0] exp;} sledb_row_t;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err, seen, press, dark;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic selftest_pass, reading_mode, good_read, result2_out, illum_req;
	logic continuous_mode, interval_end, ser_tx_busy, key_n, eth_link, eth_traffic;
	logic led_ready_orange, led_ready_green, led_result, led_illum, led_tx;
	logic led_eth_link, led_eth_data, illum_en, beep_out, irq;
	int beeps, b0, n_errors, cmp_count;
	// rows: {mode,result2,illum,continuous,link,traffic} -> {green,result,illum,link,data}
	sledb_row_t rows [6] = '{'{6'b000000, 5'b00000}, '{6'b100010, 5'b10010},
		'{6'b111011, 5'b11111}, '{6'b100100, 5'b10100}, '{6'b011001, 5'b01101},
		'{6'b000000, 5'b00000}};

	sledb_top #(.ILLUM_TO_CYCLES(TO_CYC), .SHOW_CYCLES(SHOW), .FLICK_CYCLES(FLICK)) DUT (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .selftest_pass(selftest_pass), .reading_mode(reading_mode),
		.good_read(good_read), .result2_out(result2_out), .illum_req(illum_req),
		.continuous_mode(continuous_mode), .interval_end(interval_end),
		.ser_tx_busy(ser_tx_busy), .key_n(key_n), .eth_link(eth_link),
		.eth_traffic(eth_traffic), .led_ready_orange(led_ready_orange),
		.led_ready_green(led_ready_green), .led_result(led_result), .led_illum(led_illum),
		.led_tx(led_tx), .led_eth_link(led_eth_link), .led_eth_data(led_eth_data),
		.illum_en(illum_en), .beep_out(beep_out), .irq(irq));
	sledb_operator op (.clk(clk), .press(press), .key_n(key_n), .beep_out(beep_out),
		.beeps(beeps));

	// =====================================================
	// clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// =====================================================
	// helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			$display("ERROR pready expected 1 seen %b", pready);
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// reset mid-run also clears all device state inputs
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		{selftest_pass, reading_mode, good_read, result2_out, illum_req} <= '0;
		{continuous_mode, interval_end, ser_tx_busy, eth_link, eth_traffic, press} <= '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	// early exit once a beep is heard after the mark b0
	task automatic hear(input int lim);
		seen = 1'b0;
		for (int i = 0; i < lim && !seen; i++) begin
			@(posedge clk);
			seen = (beeps != b0);
		end
	endtask
	task automatic pulse_good();
		good_read <= 1'b1;
		@(posedge clk);
		good_read <= 1'b0;
	endtask
	task automatic press_key();
		press <= 1'b1;
		repeat (10) @(posedge clk);
		press <= 1'b0;
	endtask

	// =====================================================
	// main sequence
	initial begin
		{rst, psel, penable, pwrite, press} = 5'b10000;
		paddr = '0;
		pwdata = '0;
		{selftest_pass, reading_mode, good_read, result2_out, illum_req} = '0;
		{continuous_mode, interval_end, ser_tx_busy, eth_link, eth_traffic} = '0;
		n_errors = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("outputs after reset", 32'h0, {led_ready_orange, led_ready_green, beep_out, irq});
		apb(1'b0, sledb_pkg::OFF_CTRL, 32'h0);
		chk("ctrl reset", 32'h7, rd);
		apb(1'b0, sledb_pkg::OFF_IRQ_MASK, 32'h0);
		chk("mask reset", 32'h0, rd);
		apb(1'b0, sledb_pkg::OFF_ILLUM_TO, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		$display("registers done");
		// led table, each row held well past the pin delay
		foreach (rows[i]) begin
			@(posedge clk);
			{reading_mode, result2_out, illum_req, continuous_mode, eth_link, eth_traffic} <= rows[i].in;
			repeat (8) @(posedge clk);
			@(negedge clk);
			chk("led row", rows[i].exp, {led_ready_green, led_result, led_illum, led_eth_link, led_eth_data});
		end
		$display("led table done");
		// transmit activity must be seen lit, then go dark once idle
		@(posedge clk);
		ser_tx_busy <= 1'b1;
		seen = 1'b0;
		dark = 1'b0;
		// sampled mid-cycle; dark after lit while still busy is the flicker
		repeat (40) begin
			@(negedge clk);
			if (led_tx === 1'b1) begin
				seen = 1'b1;
			end else if (seen) begin
				dark = 1'b1;
			end
		end
		chk("tx lit", 32'h1, {31'h0, seen});
		chk("tx flicker", 32'h1, {31'h0, dark});
		@(posedge clk);
		ser_tx_busy <= 1'b0;
		repeat (3 * FLICK + 6) @(posedge clk);
		@(negedge clk);
		chk("tx dark", 32'h0, {31'h0, led_tx});
		$display("tx done");
		// self-test pass: show, tone, interrupt set, masked, cleared
		do_reset();
		b0 = beeps;
		selftest_pass <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("show leds", 32'h7, {led_ready_orange, led_result, led_illum});
		hear(5000);
		chk("powerup tone", 32'h1, {31'h0, seen});
		repeat (SHOW + 5) @(posedge clk);
		@(negedge clk);
		chk("show over", 32'h0, {31'h0, led_ready_orange});
		apb(1'b0, sledb_pkg::OFF_IRQ_ST, 32'h0);
		chk("selftest status", 32'h1, {31'h0, rd[sledb_pkg::IRQ_SELFTEST]});
		// a mask bit of one lets its status bit reach the pin
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, sledb_pkg::OFF_IRQ_MASK, 32'hF);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b1, sledb_pkg::OFF_IRQ_ST, 32'h1);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("selftest done");
		// good read beeps by default, silent with beep_on_good off
		do_reset();
		reading_mode <= 1'b1;
		b0 = beeps;
		pulse_good();
		hear(5000);
		chk("good read tone", 32'h1, {31'h0, seen});
		apb(1'b0, sledb_pkg::OFF_IRQ_ST, 32'h0);
		chk("good status", 32'h1, {31'h0, rd[sledb_pkg::IRQ_GOOD]});
		do_reset();
		apb(1'b1, sledb_pkg::OFF_CTRL, 32'h3);
		reading_mode <= 1'b1;
		b0 = beeps;
		pulse_good();
		hear(3000);
		chk("good read silent", 32'h0, {31'h0, seen});
		$display("good read done");
		// function key enabled, then disabled
		do_reset();
		b0 = beeps;
		press_key();
		hear(5000);
		chk("key tone", 32'h1, {31'h0, seen});
		apb(1'b0, sledb_pkg::OFF_IRQ_ST, 32'h0);
		chk("key status", 32'h1, {31'h0, rd[sledb_pkg::IRQ_KEY]});
		// interval end inside a key interval: fast high tone, interval closed
		interval_end <= 1'b1;
		@(posedge clk);
		interval_end <= 1'b0;
		b0 = beeps;
		repeat (40) @(posedge clk);
		chk("key end high beep", 32'h1, {31'h0, (beeps - b0) > 10});
		apb(1'b0, sledb_pkg::OFF_STAT, 32'h0);
		chk("key interval closed", 32'h0, {31'h0, rd[4]});
		chk("beeper busy", 32'h1, {31'h0, rd[5]});
		do_reset();
		apb(1'b1, sledb_pkg::OFF_CTRL, 32'h5);
		b0 = beeps;
		press_key();
		hear(3000);
		chk("key off silent", 32'h0, {31'h0, seen});
		apb(1'b0, sledb_pkg::OFF_IRQ_ST, 32'h0);
		chk("key off status", 32'h0, {31'h0, rd[sledb_pkg::IRQ_KEY]});
		$display("key done");
		// illumination timeout in reading mode
		do_reset();
		reading_mode <= 1'b1;
		illum_req <= 1'b1;
		b0 = beeps;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("illum on", 32'h1, {31'h0, illum_en});
		repeat (TO_CYC + 10) @(posedge clk);
		@(negedge clk);
		chk("illum timed out", 32'h0, {31'h0, illum_en});
		chk("ready kept", 32'h1, {31'h0, led_ready_green});
		hear(5000);
		chk("timeout tone", 32'h1, {31'h0, seen});
		apb(1'b0, sledb_pkg::OFF_IRQ_ST, 32'h0);
		chk("timeout status", 32'h1, {31'h0, rd[sledb_pkg::IRQ_ILLUM_TO]});
		$display("timeout done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
